// ---- asr_serial_readout.sv ----
// Slave serial readout port of the sampling converter, running on the core clock and paced by the host's shift clock.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"

module asr_serial_readout #(
  parameter int RESULT_W = `ASR_RESULT_W
) (
  // Clock and reset.
  input  wire logic                CLOCK,
  input  wire logic                RESETN,
  // Static configuration.
  input  wire logic                CLOCK_SOURCE_SELECT,
  input  wire logic                SERIAL_PARALLEL_SELECT,
  input  wire logic                READ_DURING_CONV,
  // Conversion core, same clock domain.
  input  wire logic                BUSY,
  input  wire logic [RESULT_W-1:0] RESULT,
  // Host pins.
  input  wire logic                SCLK,
  input  wire logic                CS_N,
  input  wire logic                RD_N,
  input  wire logic                CHAIN_SERIAL_INPUT,
  // Serial output and its enable.
  output logic                     SERIAL_RESULT_OUT,
  output logic                     SERIAL_RESULT_OE,
  // Overrun pulse.
  output logic                     READ_OVERRUN_FLAG
);

  localparam int CW = $clog2(RESULT_W + 1);

  if (RESULT_W < 2) begin : g_bad_result_w
    $error("asr_serial_readout needs a result of at least two bits.");
  end
  if (`ASR_SCLK_MIN_CYCLES < `ASR_SCLK_CYCLES_NEED) begin : g_bad_clock
    $error("Core clock too slow to follow the fastest shift clock.");
  end

  // Counter arithmetic used in several places.
  function automatic logic [CW-1:0] cnt_of(input int value);
    cnt_of = CW'(value);
  endfunction

  asr_pkg::asr_pins_t pins_raw;
  asr_pkg::asr_pins_t pins_s;

  logic                prev_sclk;
  logic                prev_busy;
  logic                prev_sel;
  logic                next_prev_sclk;
  logic                next_prev_busy;
  logic                next_prev_sel;

  asr_pkg::asr_state_t state;
  asr_pkg::asr_state_t next_state;
  logic [CW-1:0]       count;
  logic [CW-1:0]       next_count;
  logic [RESULT_W-1:0] shreg;
  logic [RESULT_W-1:0] next_shreg;
  logic [RESULT_W-1:0] held;
  logic [RESULT_W-1:0] next_held;
  logic                chain_bit;
  logic                next_chain_bit;
  logic                armed;
  logic                next_armed;
  logic                overrun;
  logic                next_overrun;

  logic                active;
  logic                gated;
  logic                sel;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                busy_fall;
  logic                sel_start;
  logic                chain_in;

  // The host pins arrive from another clock domain.
  always_comb begin
    pins_raw.sclk  = SCLK;
    pins_raw.cs_n  = CS_N;
    pins_raw.rd_n  = RD_N;
    pins_raw.chain = CHAIN_SERIAL_INPUT;
  end

  // Selects reset to their inactive level, so the output is not enabled in and just after reset.
  asr_pin_sync #(
    .W           ($bits(asr_pkg::asr_pins_t)),
    .RESET_VALUE (asr_pkg::asr_pins_t'{sclk: 1'h0, cs_n: 1'h1, rd_n: 1'h1, chain: 1'h0})
  ) u_pin_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // Edges are found by oversampling, so the host clock may stop in either level.
  always_comb begin
    active    = CLOCK_SOURCE_SELECT & SERIAL_PARALLEL_SELECT;
    gated     = active & ~pins_s.cs_n;
    sel       = gated & ~pins_s.rd_n;
    sclk_rise = gated & pins_s.sclk & ~prev_sclk;
    sclk_fall = gated & ~pins_s.sclk & prev_sclk;
    busy_fall = prev_busy & ~BUSY;
    sel_start = sel & ~prev_sel;
    chain_in  = READ_DURING_CONV ? 1'h0 : pins_s.chain;
  end

  always_comb begin
    next_prev_sclk = pins_s.sclk;
    next_prev_busy = BUSY;
    next_prev_sel  = sel;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      prev_sclk <= 1'h0;
      prev_busy <= 1'h0;
      prev_sel  <= 1'h0;
    end else begin
      prev_sclk <= next_prev_sclk;
      prev_busy <= next_prev_busy;
      prev_sel  <= next_prev_sel;
    end
  end

  // A falling edge only shifts after a rising edge since the word was loaded or reloaded, so a clock
  // that idles high does not lose the top bit on its first edge.
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_shreg     = shreg;
    next_held      = held;
    next_chain_bit = chain_bit;
    next_armed     = armed;
    next_overrun   = 1'h0;
    if (busy_fall) begin
      next_overrun = READ_DURING_CONV & (state == asr_pkg::ASR_SHIFT);
      next_held    = RESULT;
      next_shreg   = RESULT;
      next_count   = cnt_of(0);
      next_state   = asr_pkg::ASR_IDLE;
      next_armed   = 1'h0;
    end else if (sel_start && state == asr_pkg::ASR_DONE) begin
      next_shreg = held;
      next_count = cnt_of(0);
      next_state = asr_pkg::ASR_IDLE;
      next_armed = 1'h0;
    end else begin
      if (sclk_rise) begin
        next_chain_bit = chain_in;
        next_armed     = 1'h1;
      end
      if (sclk_fall && armed) begin
        next_shreg = {shreg[RESULT_W-2:0], chain_bit};
        unique case (state)
          asr_pkg::ASR_IDLE: begin
            next_count = cnt_of(1);
            next_state = asr_pkg::ASR_SHIFT;
          end
          asr_pkg::ASR_SHIFT: begin
            next_count = CW'(count + cnt_of(1));
            if (count == cnt_of(RESULT_W - 1)) begin
              next_state = asr_pkg::ASR_DONE;
            end
          end
          asr_pkg::ASR_DONE: begin
            next_count = count;
          end
          default: begin
            next_state = asr_pkg::ASR_IDLE;
            next_count = cnt_of(0);
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state     <= asr_pkg::ASR_IDLE;
      count     <= '0;
      shreg     <= '0;
      held      <= '0;
      chain_bit <= 1'h0;
      armed     <= 1'h0;
      overrun   <= 1'h0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      shreg     <= next_shreg;
      held      <= next_held;
      chain_bit <= next_chain_bit;
      armed     <= next_armed;
      overrun   <= next_overrun;
    end
  end

  // Data comes straight from the shift register flop; the enable is combinational.
  assign SERIAL_RESULT_OUT = shreg[RESULT_W-1];
  assign SERIAL_RESULT_OE  = sel;
  assign READ_OVERRUN_FLAG = overrun;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  output_release_a: assert property (
    (pins_s.cs_n || pins_s.rd_n) |-> !SERIAL_RESULT_OE
  ) else $error("Output driven while chip select or read enable is high.");

  no_int_clock_a: assert property (
    !CLOCK_SOURCE_SELECT |-> !SERIAL_RESULT_OE && !sclk_fall && !sclk_rise
  ) else $error("Readout active without the external clock source.");

  load_on_busy_a: assert property (
    busy_fall |=> shreg == $past(RESULT) && count == cnt_of(0) && state == asr_pkg::ASR_IDLE
  ) else $error("Result not loaded when busy fell.");

  msb_first_a: assert property (
    busy_fall ##1 !sclk_fall [*2] |-> SERIAL_RESULT_OUT == $past(RESULT[RESULT_W-1], 2)
  ) else $error("Top bit not presented first.");

  bit_count_a: assert property (
    (sclk_fall && armed && !busy_fall && !sel_start && state == asr_pkg::ASR_SHIFT)
      |=> count == CW'($past(count) + cnt_of(1))
  ) else $error("Bit count did not advance on a shift edge.");

  clock_gated_a: assert property (
    (pins_s.cs_n && !busy_fall) |=> $stable(shreg) && $stable(count)
  ) else $error("Shift register moved while deselected.");

  overrun_pulse_a: assert property (
    (busy_fall && READ_DURING_CONV && state == asr_pkg::ASR_SHIFT) |=> READ_OVERRUN_FLAG ##1 !READ_OVERRUN_FLAG
  ) else $error("Overrun not pulsed for one cycle.");

  overrun_cause_a: assert property (
    READ_OVERRUN_FLAG |-> $past(busy_fall) && $past(READ_DURING_CONV) && $past(state == asr_pkg::ASR_SHIFT)
  ) else $error("Overrun without an unfinished read-during transfer.");

  chain_ignored_a: assert property (
    (sclk_rise && READ_DURING_CONV && !busy_fall && !sel_start) |=> !chain_bit
  ) else $error("Chain input used in read-during mode.");

  chain_sample_a: assert property (
    (sclk_rise && !READ_DURING_CONV && !busy_fall && !sel_start) |=> chain_bit == $past(pins_s.chain)
  ) else $error("Chain input not sampled on the rising edge.");

  chain_follow_a: assert property (
    (sclk_fall && armed && state == asr_pkg::ASR_SHIFT && count == cnt_of(RESULT_W - 1) && !busy_fall)
      |=> state == asr_pkg::ASR_DONE && shreg[0] == $past(chain_bit)
  ) else $error("Upstream bit does not follow the last own bit.");

  full_read_c: cover property (
    state == asr_pkg::ASR_SHIFT ##[1:1000] state == asr_pkg::ASR_DONE
  );

  overrun_c: cover property (READ_OVERRUN_FLAG);

  chain_pass_c: cover property (
    state == asr_pkg::ASR_DONE && sclk_fall && !READ_DURING_CONV && chain_bit
  );

  reread_c: cover property (sel_start && state == asr_pkg::ASR_DONE);

endmodule
`default_nettype wire

// ---- asr_params.svh ----
// Constants for the serial result readout port of the sampling converter.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// Result word width and the number of synchroniser stages.
`define ASR_RESULT_W          16
`define ASR_SYNC_STAGES       2

// Core clock period and the fastest external shift clock, in their own units.
`define ASR_CLOCK_PERIOD_PS   4000
`define ASR_SCLK_MAX_MHZ      40
`define ASR_PS_PER_US         1000000

// Core cycles in one fastest shift clock period, rounded down.
`define ASR_SCLK_MIN_CYCLES   ((`ASR_PS_PER_US / `ASR_SCLK_MAX_MHZ) / `ASR_CLOCK_PERIOD_PS)

// Edge detection after two flops needs at least two core cycles per clock phase.
`define ASR_SCLK_CYCLES_NEED  4

`endif

// ---- asr_pkg.sv ----
// Types shared by the serial result readout port.
`default_nettype none
package asr_pkg;

  // Raw pins from the host, synchronised as one group.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic rd_n;
    logic chain;
  } asr_pins_t;

  // Readout progress within one result word.
  typedef enum logic [2:0] {
    ASR_IDLE  = 3'h1,
    ASR_SHIFT = 3'h2,
    ASR_DONE  = 3'h4
  } asr_state_t;

endpackage
`default_nettype wire

// ---- asr_pin_sync.sv ----
// Two-flop synchroniser for a group of pins.
`timescale 1ns/1ps
`default_nettype none
`include "asr_params.svh"

module asr_pin_sync #(
  parameter int           W           = 4,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous pins in, synchronised levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  if (W < 1) begin : g_bad_width
    $error("asr_pin_sync needs at least one bit.");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      q    <= RESET_VALUE;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule
`default_nettype wire

// ---- asr_host_model.sv ----
// Host model that masters the shift clock of the serial readout port.
`timescale 1ns/1ps
`default_nettype none

module asr_host_model (
  // Serial line from the port.
  input  wire logic sdo,
  input  wire logic oe,
  // Pins toward the port.
  output logic      sclk,
  output logic      cs_n,
  output logic      rd_n,
  output logic      chain
);
  logic [31:0] rise_word;
  logic [31:0] fall_word;
  logic        oe_any;
  logic        line;

  // A released line shows the inverse of the data, so a read without enable cannot match.
  assign line = oe ? sdo : ~sdo;

  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    chain = 1'b0;
  end

  // Clocks n bits; each bit is taken at the rising edge and again at the next falling edge.
  task automatic xfer(input int n, input int half, input logic idle, input logic rd, input logic [31:0] ch);
    rise_word = 32'h0;
    fall_word = 32'h0;
    oe_any    = 1'b0;
    // The clock settles at its idle level before select, so no edge lands inside the frame.
    sclk      = idle;
    #(half);
    cs_n      = 1'b0;
    rd_n      = rd;
    #(2 * half);
    for (int i = 0; i < n; i++) begin
      chain = ch[n-1-i];
      sclk  = 1'b0;
      #(half);
      sclk      = 1'b1;
      rise_word = {rise_word[30:0], line};
      oe_any    = oe_any | oe;
      #(half);
      fall_word = {fall_word[30:0], line};
    end
    // The clock stands still at its idle level once the frame is over.
    sclk = idle;
    #(half);
    cs_n = 1'b1;
    rd_n = 1'b1;
    #(2 * half);
  endtask
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the serial result readout port.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clock;
  logic        resetn;
  logic        ext_sel;
  logic        ser_sel;
  logic        rd_during;
  logic        busy;
  logic [15:0] result;
  logic        sdo;
  logic        oe;
  logic        overrun;
  logic        sclk;
  logic        cs_n;
  logic        rd_n;
  logic        chain;
  int          failures;
  int          checks_done;
  int          ovr_cnt;

  asr_serial_readout #(.RESULT_W(16)) dut_u (
    .CLOCK                  (clock),
    .RESETN                 (resetn),
    .CLOCK_SOURCE_SELECT    (ext_sel),
    .SERIAL_PARALLEL_SELECT (ser_sel),
    .READ_DURING_CONV       (rd_during),
    .BUSY                   (busy),
    .RESULT                 (result),
    .SCLK                   (sclk),
    .CS_N                   (cs_n),
    .RD_N                   (rd_n),
    .CHAIN_SERIAL_INPUT     (chain),
    .SERIAL_RESULT_OUT      (sdo),
    .SERIAL_RESULT_OE       (oe),
    .READ_OVERRUN_FLAG      (overrun)
  );

  asr_host_model host_u (
    .sdo   (sdo),
    .oe    (oe),
    .sclk  (sclk),
    .cs_n  (cs_n),
    .rd_n  (rd_n),
    .chain (chain)
  );

  always #2 clock = ~clock;

  always @(posedge clock) begin
    if (overrun === 1'b1) begin
      ovr_cnt++;
    end
  end

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Busy changes 1 ns after a clock edge; the result word is valid when busy falls.
  task automatic set_busy(input logic level, input logic [15:0] value);
    @(posedge clock);
    #1;
    result = value;
    busy   = level;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic convert(input logic [15:0] value);
    set_busy(1'b1, value);
    set_busy(1'b0, value);
  endtask

  task automatic read(input int n, input int half, input logic idle, input logic rd, input logic [31:0] ch);
    @(posedge clock);
    #1;
    host_u.xfer(n, half, idle, rd, ch);
  endtask

  task automatic check_word(input logic [31:0] exp);
    compare("word on rising edge", exp, host_u.rise_word);
    compare("word on falling edge", exp, host_u.fall_word);
    compare("enable during read", 32'h1, {31'h0, host_u.oe_any});
  endtask

  initial begin
    clock       = 1'b0;
    resetn      = 1'b0;
    ext_sel     = 1'b1;
    ser_sel     = 1'b1;
    rd_during   = 1'b0;
    busy        = 1'b0;
    result      = 16'h0;
    failures    = 0;
    checks_done = 0;
    ovr_cnt     = 0;
    repeat (12) @(posedge clock);
    compare("enable in reset", 32'h0, {31'h0, oe});
    #1;
    resetn = 1'b1;
    @(posedge clock);
    #1;
    compare("enable after reset", 32'h0, {31'h0, oe});
    repeat (3) @(posedge clock);
    #1;
    compare("enable while deselected", 32'h0, {31'h0, oe});
    convert(16'ha5c3);
    read(20, 16, 1'b0, 1'b0, 32'h000b0000);
    check_word(32'h000a5c3b);
    read(16, 16, 1'b0, 1'b0, 32'h0);
    check_word(32'h0000a5c3);
    convert(16'h3c96);
    read(16, 16, 1'b1, 1'b0, 32'h0);
    check_word(32'h00003c96);
    convert(16'h81e7);
    read(8, 16, 1'b0, 1'b0, 32'h0);
    check_word(32'h00000081);
    read(8, 16, 1'b0, 1'b0, 32'h0);
    check_word(32'h000000e7);
    rd_during = 1'b1;
    convert(16'h5a0f);
    set_busy(1'b1, 16'hf00d);
    read(20, 16, 1'b0, 1'b0, 32'hffffffff);
    check_word(32'h0005a0f0);
    ovr_cnt = 0;
    set_busy(1'b0, 16'hf00d);
    compare("overrun after full read", 32'h0, ovr_cnt);
    set_busy(1'b1, 16'h1234);
    read(8, 16, 1'b0, 1'b0, 32'h0);
    check_word(32'h000000f0);
    set_busy(1'b0, 16'h1234);
    compare("overrun after partial read", 32'h1, ovr_cnt);
    read(16, 16, 1'b0, 1'b0, 32'h0);
    check_word(32'h00001234);
    read(16, 16, 1'b0, 1'b1, 32'h0);
    compare("enable with read high", 32'h0, {31'h0, host_u.oe_any});
    rd_during = 1'b0;
    for (int m = 0; m < 2; m++) begin
      ext_sel = (m == 1);
      ser_sel = (m == 0);
      convert(16'h6b2d);
      read(16, 16, 1'b0, 1'b0, 32'h0);
      compare("enable when inert", 32'h0, {31'h0, host_u.oe_any});
    end
    results();
  end

  // The whole sequence takes about 6.5 us; the limit leaves ample margin.
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule

`default_nettype wire
